// ---- rtl/hmcsr_top.sv ----
// Purpose: Control and status register bank of a system hardware monitor
// Assumes: Link side on its own clock; measurement side on the core clock
// Notes: Link requests cross by toggle handshake, words held stable meanwhile

////////////////////////////////////////////////////////////////////////////
// Operation
// - Config bit 0 runs the monitor when one, standby when zero, resets zero.
// - Writing config bit 4 gives a 20 ms low pulse if enabled.
// - Config bit 5 picks pin 11 role: zero analog 12 V, one code bit 4.
// - Writing config bit 7 restores config and both status registers to defaults.
// - Re-initialisation bit clears itself, reads zero, resets to zero.
// - Status one bits 0-3 flag 2.5 V, core, 3.3 V, 5 V violations.
// - Status one bit 4 flags local temperature limit crossing.
// - Status one bit 5 flags remote temperature crossing; bits 6-7 reserved.
// - Both status registers reset to zero; status one is read-only.
// - Status two bit 0 flags 12 V, bit 1 supply; bits 2-5 and 7 read zero.
// - Status two bit 6 flags short or open remote diode.
// - Voltage-code bits 0-3 read the four low code pins; bits 4-5 read-only.
// - Voltage-code bit 6 routes offset internal only with test bit 0 and no bit 7.
// - Voltage-code bit 7 enables pin 16 reset output; resets to zero.
// - High code register bit 0 shows code bit 4 pin when selected.
// - Error when reading above high limit or at or below low limit.
module hmcsr_top #(
  parameter int unsigned PULSE_CYCLES = hmcsr_pkg::RST_PULSE_CYCLES
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link side
  input wire logic link_clock,
  input wire logic link_req,
  input wire hmcsr_pkg::hmcsr_req_t link_req_word,
  output logic link_busy,
  output logic link_done,
  output logic [7:0] link_rd_data,
  // Measurement side
  input wire hmcsr_pkg::hmcsr_chan_t [hmcsr_pkg::NUM_CHAN-1:0] meas,
  input wire logic cycle_done,
  input wire logic diode_fault,
  input wire logic test_bit0,
  // Code pins
  input wire logic [3:0] voltage_code_low_bits,
  input wire logic voltage_code_bit4,
  // Control outputs
  output logic monitor_run,
  output logic pin11_function_select,
  output logic offset_to_internal,
  // Pin 16 open-drain reset
  output logic reset_pulse_out,
  output logic reset_pulse_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: capture and handshake
  hmcsr_pkg::hmcsr_req_t req_hold;
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic ack_seen;
  logic ack_tgl;
  logic [7:0] rd_word;
  wire link_take = link_req && !link_busy;
  wire link_ack_edge = ack_s2 ^ ack_seen;

  assign link_busy = req_tgl ^ ack_seen;

  always_ff @(posedge link_clock or negedge rst_n) begin
    if (!rst_n) begin
      req_hold <= '0;
      req_tgl <= 1'b0;
    end else if (link_take) begin
      req_hold <= link_req_word;
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge link_clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_seen <= 1'b0;
      link_done <= 1'b0;
      link_rd_data <= 8'h00;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_seen <= ack_s2;
      link_done <= link_ack_edge;
      if (link_ack_edge) begin
        link_rd_data <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers
  logic req_s1;
  logic req_s2;
  logic [3:0] vcl_s1;
  logic [3:0] vcl_s2;
  logic vb4_s1;
  logic vb4_s2;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      vcl_s1 <= 4'h0;
      vcl_s2 <= 4'h0;
      vb4_s1 <= 1'b0;
      vb4_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      vcl_s1 <= voltage_code_low_bits;
      vcl_s2 <= vcl_s1;
      vb4_s1 <= voltage_code_bit4;
      vb4_s2 <= vb4_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic [7:0] register_index;
  logic cfg_run;
  logic cfg_select;
  logic vc_offset;
  logic vc_rsten;
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic [hmcsr_pkg::PULSE_CNT_W-1:0] pulse_count;

  wire access = req_s2 ^ ack_tgl;
  wire acc_index = access && req_hold.write && req_hold.index;
  wire acc_data_wr = access && req_hold.write && !req_hold.index;
  wire acc_read = access && !req_hold.write;
  wire [7:0] wdata = req_hold.data;
  wire cfg_wr = acc_data_wr && (register_index == hmcsr_pkg::IDX_MONITOR_CONFIG);
  wire vc_wr = acc_data_wr && (register_index == hmcsr_pkg::IDX_VOLTAGE_CODE);
  wire do_init = cfg_wr && wdata[hmcsr_pkg::CFG_INIT_BIT];
  wire pulse_start = cfg_wr && wdata[hmcsr_pkg::CFG_PULSE_BIT] && vc_rsten;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] cfg_read = {1'b0, 1'b0, cfg_select, 1'b0, 1'b1, 1'b0, 1'b0, cfg_run};
  wire [7:0] vc_read = {vc_rsten, vc_offset, 2'b00, vcl_s2};
  wire [7:0] vch_read = {1'b1, 6'h00, cfg_select & vb4_s2};
  wire [7:0] rd_mux =
    (register_index == hmcsr_pkg::IDX_MAKER_ID) ? hmcsr_pkg::MAKER_ID_VALUE :
    (register_index == hmcsr_pkg::IDX_REVISION_ID) ? hmcsr_pkg::REVISION_ID_VALUE :
    (register_index == hmcsr_pkg::IDX_MONITOR_CONFIG) ? cfg_read :
    (register_index == hmcsr_pkg::IDX_ERROR_FLAGS_ONE) ? flags_one :
    (register_index == hmcsr_pkg::IDX_ERROR_FLAGS_TWO) ? flags_two :
    (register_index == hmcsr_pkg::IDX_VOLTAGE_CODE) ? vc_read :
    (register_index == hmcsr_pkg::IDX_VOLTAGE_CODE_HIGH) ? vch_read :
    hmcsr_pkg::READ_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Index, handshake acknowledge and read word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      register_index <= 8'h00;
      ack_tgl <= 1'b0;
      rd_word <= 8'h00;
    end else begin
      if (access) begin
        ack_tgl <= ~ack_tgl;
      end
      if (acc_index) begin
        register_index <= wdata;
      end
      if (acc_read) begin
        rd_word <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and voltage-code control bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_run <= hmcsr_pkg::CFG_RESET[hmcsr_pkg::CFG_RUN_BIT];
      cfg_select <= hmcsr_pkg::CFG_RESET[hmcsr_pkg::CFG_SELECT_BIT];
      vc_offset <= 1'b0;
      vc_rsten <= 1'b0;
    end else begin
      if (do_init) begin
        cfg_run <= hmcsr_pkg::CFG_RESET[hmcsr_pkg::CFG_RUN_BIT];
        cfg_select <= hmcsr_pkg::CFG_RESET[hmcsr_pkg::CFG_SELECT_BIT];
      end else if (cfg_wr) begin
        cfg_run <= wdata[hmcsr_pkg::CFG_RUN_BIT];
        cfg_select <= wdata[hmcsr_pkg::CFG_SELECT_BIT];
      end
      if (vc_wr) begin
        vc_offset <= wdata[hmcsr_pkg::VC_OFFSET_BIT];
        vc_rsten <= wdata[hmcsr_pkg::VC_RSTEN_BIT];
      end
    end
  end

  assign monitor_run = cfg_run;
  assign pin11_function_select = cfg_select;
  assign offset_to_internal = vc_offset && test_bit0 && !vc_rsten;

  ////////////////////////////////////////////////////////////////////////////
  // Limit compare
  logic [hmcsr_pkg::NUM_CHAN-1:0] viol;
  genvar gi;
  generate
    for (gi = 0; gi < hmcsr_pkg::NUM_CHAN; gi++) begin : g_cmp
      assign viol[gi] = (meas[gi].value > meas[gi].high) || (meas[gi].value <= meas[gi].low);
    end
  endgenerate

  // 12 V compare only while pin 11 is the analog input
  wire update = cycle_done && cfg_run;
  wire [7:0] set_one = update ? {2'b00, viol[hmcsr_pkg::FL1_CHANS-1:0]} : 8'h00;
  wire v12 = viol[hmcsr_pkg::CH_12V] && !cfg_select;
  wire [7:0] set_two = update ? {1'b0, diode_fault, 4'h0, viol[hmcsr_pkg::CH_SUPPLY], v12} : 8'h00;
  wire [7:0] next_flags_one = (do_init ? hmcsr_pkg::FLAGS_RESET : flags_one) | set_one;
  wire [7:0] next_flags_two = (do_init ? hmcsr_pkg::FLAGS_RESET : flags_two) | set_two;

  // Sticky flags; a new event wins over re-initialisation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_one <= hmcsr_pkg::FLAGS_RESET;
      flags_two <= hmcsr_pkg::FLAGS_RESET;
    end else begin
      flags_one <= next_flags_one;
      flags_two <= next_flags_two;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse on pin 16
  localparam logic [hmcsr_pkg::PULSE_CNT_W-1:0] PULSE_LOAD = hmcsr_pkg::PULSE_CNT_W'(PULSE_CYCLES);
  wire pulse_active = (pulse_count != '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_count <= '0;
    end else if (pulse_start) begin
      pulse_count <= PULSE_LOAD;
    end else if (pulse_active) begin
      pulse_count <= pulse_count - 1'b1;
    end
  end

  assign reset_pulse_out = 1'b0;
  assign reset_pulse_oe = pulse_active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_cfg_write;
    cfg_wr && !wdata[hmcsr_pkg::CFG_INIT_BIT];
  endsequence

  sequence seq_init_write;
    do_init;
  endsequence

  a_run_follows: assert property (@(posedge clock) disable iff (!rst_n)
    seq_cfg_write |=> monitor_run == $past(wdata[hmcsr_pkg::CFG_RUN_BIT]))
    else $error("run bit did not follow config write");

  a_select_follows: assert property (@(posedge clock) disable iff (!rst_n)
    seq_cfg_write |=> pin11_function_select == $past(wdata[hmcsr_pkg::CFG_SELECT_BIT]))
    else $error("pin 11 select did not follow config write");

  a_pulse_gated: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(reset_pulse_oe) |-> $past(vc_rsten) && $past(cfg_wr))
    else $error("reset pulse started without enable or write");

  a_pulse_length: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(reset_pulse_oe) |-> pulse_count == PULSE_LOAD)
    else $error("reset pulse not loaded with full length");

  a_init_restores: assert property (@(posedge clock) disable iff (!rst_n)
    seq_init_write ##0 !update |=> flags_one == hmcsr_pkg::FLAGS_RESET
      && flags_two == hmcsr_pkg::FLAGS_RESET && !monitor_run && !cfg_select)
    else $error("initialisation did not restore defaults");

  a_init_selfclear: assert property (@(posedge clock) disable iff (!rst_n)
    acc_read && register_index == hmcsr_pkg::IDX_MONITOR_CONFIG |=> !rd_word[hmcsr_pkg::CFG_INIT_BIT]
      && rd_word[hmcsr_pkg::CFG_FIXED_ONE_BIT])
    else $error("config read shows init bit or lost fixed bit");

  a_flag_sets: assert property (@(posedge clock) disable iff (!rst_n)
    update && viol[0] |=> flags_one[0])
    else $error("violation at cycle end did not set flag");

  a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !update && !do_init |=> $stable(flags_one) && $stable(flags_two))
    else $error("status flags changed without cause");

  a_standby_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !cfg_run && !do_init |=> $stable(flags_one))
    else $error("flags changed while in standby");

  a_vcode_read: assert property (@(posedge clock) disable iff (!rst_n)
    acc_read && register_index == hmcsr_pkg::IDX_VOLTAGE_CODE |=> rd_word[3:0] == $past(vcl_s2)
      && rd_word[5:4] == 2'b00)
    else $error("voltage code read wrong");

  a_b4_read: assert property (@(posedge clock) disable iff (!rst_n)
    acc_read && register_index == hmcsr_pkg::IDX_VOLTAGE_CODE_HIGH |=>
      rd_word[0] == $past(cfg_select && vb4_s2) && rd_word[hmcsr_pkg::VCH_FIXED_ONE_BIT])
    else $error("code bit 4 read wrong");

  a_offset_route: assert property (@(posedge clock) disable iff (!rst_n)
    vc_wr |=> offset_to_internal == ($past(wdata[hmcsr_pkg::VC_OFFSET_BIT])
      && !$past(wdata[hmcsr_pkg::VC_RSTEN_BIT]) && test_bit0))
    else $error("offset route does not follow voltage-code write");

  a_fault_flag: assert property (@(posedge clock) disable iff (!rst_n)
    update && diode_fault |=> flags_two[hmcsr_pkg::FL2_FAULT_BIT])
    else $error("diode fault not flagged");

  a_link_done: assert property (@(posedge link_clock) disable iff (!rst_n)
    link_take |-> ##[2:6] link_done)
    else $error("link request not answered in time");

endmodule

// ---- common/hmcsr_pkg.sv ----
// Purpose: Shared constants and types for the hardware monitor register bank
// Assumes: Core clock at 100 MHz
// Notes: Register offsets are the byte values the host writes as index
package hmcsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [7:0] IDX_MAKER_ID = 8'h3e;
  localparam logic [7:0] IDX_REVISION_ID = 8'h3f;
  localparam logic [7:0] IDX_MONITOR_CONFIG = 8'h40;
  localparam logic [7:0] IDX_ERROR_FLAGS_ONE = 8'h41;
  localparam logic [7:0] IDX_ERROR_FLAGS_TWO = 8'h42;
  localparam logic [7:0] IDX_VOLTAGE_CODE = 8'h47;
  localparam logic [7:0] IDX_VOLTAGE_CODE_HIGH = 8'h49;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_FIXED_ONE_BIT = 3;
  localparam int CFG_PULSE_BIT = 4;
  localparam int CFG_SELECT_BIT = 5;
  localparam int CFG_INIT_BIT = 7;
  localparam int VC_OFFSET_BIT = 6;
  localparam int VC_RSTEN_BIT = 7;
  localparam int VCH_FIXED_ONE_BIT = 7;
  localparam int FL2_FAULT_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed read values
  localparam logic [7:0] CFG_RESET = 8'h08;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Identity values are arbitrary
  localparam logic [7:0] MAKER_ID_VALUE = 8'h5a;
  localparam logic [7:0] REVISION_ID_VALUE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Channels: 0 2.5 V, 1 core_supply, 2 3.3 V, 3 5 V, 4 local temp,
  // 5 remote temp, 6 12 V, 7 supply
  localparam int NUM_CHAN = 8;
  localparam int CH_12V = 6;
  localparam int CH_SUPPLY = 7;
  localparam int FL1_CHANS = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLOCK_HZ = 100_000_000;
  localparam longint RST_PULSE_MS = 20;
  localparam int unsigned RST_PULSE_CYCLES = int'((RST_PULSE_MS * CLOCK_HZ + 999) / 1000);
  localparam int PULSE_CNT_W = 22;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] high;
    logic [7:0] low;
  } hmcsr_chan_t;

  typedef struct packed {
    logic write;
    logic index;
    logic [7:0] data;
  } hmcsr_req_t;

endpackage

// ---- dv/hmcsr_host.sv ----
// Purpose: Link-side host model for the monitor register bank
// Assumes: One request in flight at a time
// Notes: Missing answers are counted in lost for the bench
module hmcsr_host (
  // Link clock
  input wire logic link_clock,
  // Answer side
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [7:0] link_rd_data,
  // Request side
  output logic link_req,
  output hmcsr_pkg::hmcsr_req_t link_req_word
);
  timeunit 1ns;
  timeprecision 1ps;

  int lost = 0;

  initial begin
    link_req = 1'b0;
    link_req_word = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One request: index flag selects pointer load or data access
  task automatic xfer(input logic wr, input logic idx, input logic [7:0] data, output logic [7:0] rd);
    bit got;
    got = 0;
    rd = 8'hxx;
    @(posedge link_clock);
    link_req <= 1'b1;
    link_req_word <= '{write: wr, index: idx, data: data};
    @(posedge link_clock);
    link_req <= 1'b0;
    // Released word shows its inverse so a stale sample cannot pass
    link_req_word <= hmcsr_pkg::hmcsr_req_t'(~link_req_word);
    for (int i = 0; i < 20 && !got; i++) begin
      @(negedge link_clock);
      if (link_done === 1'b1) begin
        got = 1;
        rd = link_rd_data;
      end
    end
    if (!got) lost++;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the monitor register bank
// Assumes: Reset pulse shortened to PULSE core cycles
// Notes: Default reads run from a table, the rest by hand
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PULSE = 16;

  logic clock, rst_n, link_clock, link_req, link_busy, link_done;
  hmcsr_pkg::hmcsr_req_t link_req_word;
  logic [7:0] link_rd_data;
  hmcsr_pkg::hmcsr_chan_t [hmcsr_pkg::NUM_CHAN-1:0] meas;
  logic cycle_done, diode_fault, test_bit0, voltage_code_bit4;
  logic [3:0] voltage_code_low_bits;
  logic monitor_run, pin11_function_select, offset_to_internal, reset_pulse_out, reset_pulse_oe;
  int mismatches = 0;
  int n_tests = 0;
  // Index in the upper byte, expected read in the lower
  logic [15:0] rows [8] = '{16'h3e5a, 16'h3f01, 16'h4008, 16'h4100, 16'h4200, 16'h470a, 16'h4980, 16'h5000};

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7;
    forever #32 link_clock = ~link_clock;
  end

  hmcsr_top #(.PULSE_CYCLES(PULSE)) DUT (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
    .link_req(link_req), .link_req_word(link_req_word), .link_busy(link_busy), .link_done(link_done),
    .link_rd_data(link_rd_data), .meas(meas), .cycle_done(cycle_done), .diode_fault(diode_fault),
    .test_bit0(test_bit0), .voltage_code_low_bits(voltage_code_low_bits),
    .voltage_code_bit4(voltage_code_bit4), .monitor_run(monitor_run),
    .pin11_function_select(pin11_function_select), .offset_to_internal(offset_to_internal),
    .reset_pulse_out(reset_pulse_out), .reset_pulse_oe(reset_pulse_oe));

  hmcsr_host host (.link_clock(link_clock), .link_busy(link_busy), .link_done(link_done),
    .link_rd_data(link_rd_data), .link_req(link_req), .link_req_word(link_req_word));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    mismatches += host.lost;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer(1'b1, 1'b1, idx, dummy);
    host.xfer(1'b1, 1'b0, d, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b1, 1'b1, idx, v);
    host.xfer(1'b0, 1'b0, 8'h00, v);
    check(name, v, exp);
  endtask

  task automatic pulse_cycle();
    @(posedge clock);
    cycle_done <= 1'b1;
    @(posedge clock);
    cycle_done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Counts core cycles with pin 16 pulled low around a config write
  task automatic pulse_len(input logic [7:0] cfg, output int n);
    n = 0;
    fork
      wr(8'h40, cfg);
      repeat (300) @(negedge clock) if (reset_pulse_oe === 1'b1) n++;
    join
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    rst_n = 1'b0;
    cycle_done = 1'b0;
    diode_fault = 1'b0;
    test_bit0 = 1'b0;
    voltage_code_low_bits = 4'ha;
    voltage_code_bit4 = 1'b1;
    for (int c = 0; c < hmcsr_pkg::NUM_CHAN; c++) meas[c] = '{value: 8'h60, high: 8'h80, low: 8'h40};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge link_clock);
    foreach (rows[r]) rd_chk("reset_read", rows[r][15:8], rows[r][7:0]);
    @(posedge clock);
    meas[0].value <= 8'h81;
    meas[1].value <= 8'h40;
    meas[3].value <= 8'h80;
    meas[4].value <= 8'h10;
    meas[6].value <= 8'hff;
    meas[7].value <= 8'h00;
    diode_fault <= 1'b1;
    pulse_cycle();
    rd_chk("flags_standby", 8'h41, 8'h00);
    wr(8'h40, 8'h21);
    check("run", {7'h0, monitor_run}, 8'h01);
    check("select", {7'h0, pin11_function_select}, 8'h01);
    rd_chk("config", 8'h40, 8'h29);
    rd_chk("code_high", 8'h49, 8'h81);
    pulse_cycle();
    rd_chk("flags_one", 8'h41, 8'h13);
    rd_chk("flags_two", 8'h42, 8'h42);
    wr(8'h41, 8'hff);
    rd_chk("flags_one_ro", 8'h41, 8'h13);
    wr(8'h47, 8'h3f);
    rd_chk("code_ro", 8'h47, 8'h0a);
    wr(8'h40, 8'h01);
    pulse_cycle();
    rd_chk("flags_12v", 8'h42, 8'h43);
    wr(8'h40, 8'h80);
    check("run_init", {7'h0, monitor_run}, 8'h00);
    rd_chk("config_init", 8'h40, 8'h08);
    rd_chk("flags_one_init", 8'h41, 8'h00);
    rd_chk("flags_two_init", 8'h42, 8'h00);
    pulse_len(8'h10, n);
    check("pulse_off", n[7:0], 8'h00);
    @(posedge clock);
    test_bit0 <= 1'b1;
    wr(8'h47, 8'hc0);
    check("offset_blocked", {7'h0, offset_to_internal}, 8'h00);
    rd_chk("code_opts", 8'h47, 8'hca);
    pulse_len(8'h10, n);
    check("pulse_len", n[7:0], 8'(PULSE));
    check("pulse_data", {7'h0, reset_pulse_out}, 8'h00);
    rd_chk("config_pulse", 8'h40, 8'h08);
    wr(8'h47, 8'h40);
    check("offset_internal", {7'h0, offset_to_internal}, 8'h01);
    @(posedge clock);
    test_bit0 <= 1'b0;
    @(negedge clock);
    check("offset_external", {7'h0, offset_to_internal}, 8'h00);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge link_clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge link_clock);
    check("busy_idle", {7'h0, link_busy}, 8'h00);
    fork
      rd_chk("code_reset", 8'h47, 8'h0a);
      begin
        repeat (2) @(posedge link_clock);
        @(negedge link_clock);
        check("busy_taken", {7'h0, link_busy}, 8'h01);
      end
    join
    rd_chk("config_reset", 8'h40, 8'h08);
    complete_run();
  end

  initial begin
    #300_000;
    mismatches++;
    complete_run();
  end
endmodule
